// [rxsm_params.svh]
// Purpose: Offsets, field positions and reset values of the synthesizer and modem
//          configuration registers.
// Assumes: Six-bit register addresses from the serial register port.
// Notes:   Definitions only.
`ifndef RXSM_PARAMS_SVH
`define RXSM_PARAMS_SVH

// Register offsets
`define RXSM_OFF_SYNTH_CTRL 8'h0c
`define RXSM_OFF_CARRIER_HI 8'h0d
`define RXSM_OFF_CARRIER_MID 8'h0e
`define RXSM_OFF_CARRIER_LO 8'h0f
`define RXSM_OFF_BW_RATE_EXP 8'h10
`define RXSM_OFF_RATE_MANT 8'h11
`define RXSM_OFF_DEMOD_FMT 8'h12
`define RXSM_NUM_REGS 7

// Slot numbers inside the bank
`define RXSM_SLOT_SYNTH_CTRL 3'h0
`define RXSM_SLOT_CARRIER_HI 3'h1
`define RXSM_SLOT_CARRIER_MID 3'h2
`define RXSM_SLOT_CARRIER_LO 3'h3
`define RXSM_SLOT_BW_RATE_EXP 3'h4
`define RXSM_SLOT_RATE_MANT 3'h5
`define RXSM_SLOT_DEMOD_FMT 3'h6
`define RXSM_SLOT_NONE 3'h7

// Reset values
`define RXSM_RST_CARRIER_HI 8'h1e
`define RXSM_RST_CARRIER_MID 8'hc4
`define RXSM_RST_CARRIER_LO 8'hec
`define RXSM_RST_BW_RATE_EXP 8'h8c
`define RXSM_RST_RATE_MANT 8'h22
`define RXSM_RST_DEMOD_FMT 8'h02

// Writable bit masks
`define RXSM_MASK_CARRIER_HI 8'h3f
`define RXSM_MASK_FULL 8'hff

// Field positions
`define RXSM_BWE_RANGE 7:6
`define RXSM_BWM_RANGE 5:4
`define RXSM_SRE_RANGE 3:0
`define RXSM_DCBYP_BIT 7
`define RXSM_MODSEL_RANGE 6:4

// Formula constants
`define RXSM_BW_OFFSET 9'h004
`define RXSM_BW_SHIFT 4'h3
`define RXSM_SR_HIDDEN 1'h1

`endif

// [rxsm_pkg.sv]
// Purpose: Types shared by the configuration bank and its field decoder.
// Assumes: Constants come from rxsm_params.svh.
// Notes:   Types only.
package rxsm_pkg;

  typedef enum logic [2:0] {
    RXSM_MOD_FSK2 = 3'h0,
    RXSM_MOD_GFSK = 3'h1,
    RXSM_MOD_RSV2 = 3'h2,
    RXSM_MOD_OOK = 3'h3,
    RXSM_MOD_FSK4 = 3'h4,
    RXSM_MOD_RSV5 = 3'h5,
    RXSM_MOD_RSV6 = 3'h6,
    RXSM_MOD_RSV7 = 3'h7
  } rxsm_mod_t;

  typedef struct packed {
    logic [7:0] synthControl;
    logic [7:0] carrierHigh;
    logic [7:0] carrierMiddle;
    logic [7:0] carrierLow;
    logic [7:0] bwRateExp;
    logic [7:0] rateMantissa;
    logic [7:0] demodFormat;
  } rxsm_raw_t;

  typedef struct packed {
    logic [23:0] carrierWord;
    logic [1:0] bandwidthExponent;
    logic [1:0] bandwidthMantissa;
    logic [8:0] decimationRatio;
    logic [3:0] symbolRateExponent;
    logic [8:0] symbolRateMantissa;
    logic [23:0] symbolRateScale;
    logic dcBlockBypass;
    rxsm_mod_t modulationSelect;
    logic modulationValid;
    logic [7:0] synthControl;
  } rxsm_cfg_t;

endpackage : rxsm_pkg

// [rxsm_field_decode.sv]
// Purpose: Turns raw register bytes into registered synthesizer and modem settings.
// Assumes: Raw bytes are already masked by the register bank.
// Notes:   One cycle from a register write to the settings.
`timescale 1ns/1ps
`default_nettype none
`include "rxsm_params.svh"

module rxsm_field_decode
  import rxsm_pkg::*;
#(
  parameter logic [7:0] SYNTH_CTRL_RESET = 8'h00
)
(
  input wire logic clk,
  input wire logic reset,
  input wire rxsm_raw_t raw,
  output rxsm_cfg_t cfg
);

  function automatic rxsm_cfg_t decodeFields(input rxsm_raw_t r);
    rxsm_cfg_t c;
    c = '0;
    c.carrierWord = {r.carrierHigh, r.carrierMiddle, r.carrierLow};
    c.bandwidthExponent = r.bwRateExp[`RXSM_BWE_RANGE];
    c.bandwidthMantissa = r.bwRateExp[`RXSM_BWM_RANGE];
    // Ratio 8*(4+M)*2^E, at most 448, so nine bits suffice
    c.decimationRatio = (9'(r.bwRateExp[`RXSM_BWM_RANGE]) + `RXSM_BW_OFFSET)
      << (`RXSM_BW_SHIFT + 4'(r.bwRateExp[`RXSM_BWE_RANGE]));
    c.symbolRateExponent = r.bwRateExp[`RXSM_SRE_RANGE];
    c.symbolRateMantissa = {`RXSM_SR_HIDDEN, r.rateMantissa};
    c.symbolRateScale = 24'({`RXSM_SR_HIDDEN, r.rateMantissa})
      << r.bwRateExp[`RXSM_SRE_RANGE];
    c.dcBlockBypass = r.demodFormat[`RXSM_DCBYP_BIT];
    c.modulationSelect = rxsm_mod_t'(r.demodFormat[`RXSM_MODSEL_RANGE]);
    case (c.modulationSelect)
      RXSM_MOD_FSK2, RXSM_MOD_GFSK, RXSM_MOD_OOK, RXSM_MOD_FSK4: c.modulationValid = 1'b1;
      default: c.modulationValid = 1'b0;
    endcase
    c.synthControl = r.synthControl;
    return c;
  endfunction : decodeFields

  localparam rxsm_raw_t RAW_DEFAULT = '{
    synthControl: SYNTH_CTRL_RESET,
    carrierHigh: `RXSM_RST_CARRIER_HI,
    carrierMiddle: `RXSM_RST_CARRIER_MID,
    carrierLow: `RXSM_RST_CARRIER_LO,
    bwRateExp: `RXSM_RST_BW_RATE_EXP,
    rateMantissa: `RXSM_RST_RATE_MANT,
    demodFormat: `RXSM_RST_DEMOD_FMT
  };
  localparam rxsm_cfg_t CFG_DEFAULT = decodeFields(RAW_DEFAULT);

  ////////////////////////////////////////////////////////////////////////////////
  // Registered settings, defaults from reset onward
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cfg <= CFG_DEFAULT;
    end
    else
    begin
      cfg <= decodeFields(raw);
    end
  end

endmodule : rxsm_field_decode
`default_nettype wire

// [rxsm_config_regs.sv]
// Purpose: Synthesizer and modem configuration register bank of the receiver.
// Assumes: Requests arrive already deserialised from the serial register port,
//          synchronous to clk.
// Notes:   Settings reach the datapath one cycle after the bank updates.
//          Reserved modulation codes are kept and flagged, not refused.
`timescale 1ns/1ps
`default_nettype none
`include "rxsm_params.svh"

module rxsm_config_regs
  import rxsm_pkg::*;
#(
  parameter int ADDR_W = 6,
  parameter logic [7:0] SYNTH_CTRL_RESET = 8'h00
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic cfgReq,
  input wire logic cfgWrite,
  input wire logic [ADDR_W-1:0] cfgAddr,
  input wire logic [7:0] cfgWrData,
  output logic [7:0] cfgRdData,
  output logic cfgAck,
  output rxsm_cfg_t cfgOut
);

  ////////////////////////////////////////////////////////////////////////////////
  // Elaboration checks
  generate
    // Five bits are the least that reach the highest offset
    if (ADDR_W < 5)
    begin : gNarrowAddr
      $error("rxsm_config_regs: ADDR_W below 5 cannot reach every register");
    end
    // The offset decode compares eight bits
    if (ADDR_W > 8)
    begin : gWideAddr
      $error("rxsm_config_regs: ADDR_W above 8 is not decoded");
    end
    // Slot codes are three bits and the top code means unmapped
    if (`RXSM_NUM_REGS > int'(`RXSM_SLOT_NONE))
    begin : gBadBank
      $error("rxsm_config_regs: bank exceeds the slot code space");
    end
    // The raw view to the decoder must cover the bank byte for byte
    if ($bits(rxsm_raw_t) != 8 * `RXSM_NUM_REGS)
    begin : gBadRawView
      $error("rxsm_config_regs: raw view and bank size differ");
    end
    // A default with the top carrier bits set could never be read back
    if ((`RXSM_RST_CARRIER_HI & ~`RXSM_MASK_CARRIER_HI) != 8'h00)
    begin : gBadCarrierReset
      $error("rxsm_config_regs: carrier high default sets read-only bits");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode, shared by the write and read paths
  function automatic logic [2:0] regSlot(input logic [7:0] a);
    case (a)
      `RXSM_OFF_SYNTH_CTRL: regSlot = `RXSM_SLOT_SYNTH_CTRL;
      `RXSM_OFF_CARRIER_HI: regSlot = `RXSM_SLOT_CARRIER_HI;
      `RXSM_OFF_CARRIER_MID: regSlot = `RXSM_SLOT_CARRIER_MID;
      `RXSM_OFF_CARRIER_LO: regSlot = `RXSM_SLOT_CARRIER_LO;
      `RXSM_OFF_BW_RATE_EXP: regSlot = `RXSM_SLOT_BW_RATE_EXP;
      `RXSM_OFF_RATE_MANT: regSlot = `RXSM_SLOT_RATE_MANT;
      `RXSM_OFF_DEMOD_FMT: regSlot = `RXSM_SLOT_DEMOD_FMT;
      default: regSlot = `RXSM_SLOT_NONE;
    endcase
  endfunction : regSlot

  ////////////////////////////////////////////////////////////////////////////////
  // Per-slot constants, shared by storage, read path and reset
  // Carrier high byte keeps bits 7:6 clear so they can never read back as one
  function automatic logic [7:0] slotMask(input logic [2:0] s);
    case (s)
      `RXSM_SLOT_CARRIER_HI: slotMask = `RXSM_MASK_CARRIER_HI;
      `RXSM_SLOT_NONE: slotMask = '0;
      default: slotMask = `RXSM_MASK_FULL;
    endcase
  endfunction : slotMask

  // Defaults per slot; the synthesizer control byte is left to the integrator
  function automatic logic [7:0] slotReset(input logic [2:0] s);
    case (s)
      `RXSM_SLOT_SYNTH_CTRL: slotReset = SYNTH_CTRL_RESET;
      `RXSM_SLOT_CARRIER_HI: slotReset = `RXSM_RST_CARRIER_HI;
      `RXSM_SLOT_CARRIER_MID: slotReset = `RXSM_RST_CARRIER_MID;
      `RXSM_SLOT_CARRIER_LO: slotReset = `RXSM_RST_CARRIER_LO;
      `RXSM_SLOT_BW_RATE_EXP: slotReset = `RXSM_RST_BW_RATE_EXP;
      `RXSM_SLOT_RATE_MANT: slotReset = `RXSM_RST_RATE_MANT;
      `RXSM_SLOT_DEMOD_FMT: slotReset = `RXSM_RST_DEMOD_FMT;
      default: slotReset = '0;
    endcase
  endfunction : slotReset

  ////////////////////////////////////////////////////////////////////////////////
  // Internal signals
  logic [7:0] addrWide;
  logic [2:0] slot;
  logic wrHit;
  logic rdHit;
  logic [`RXSM_NUM_REGS-1:0] wrEn;
  logic [7:0] regFile_r [`RXSM_NUM_REGS];
  logic [7:0] rdData_nxt;
  rxsm_raw_t rawRegs;

  assign addrWide = 8'(cfgAddr);
  assign slot = regSlot(addrWide);
  // Writes to unmapped offsets are dropped silently, yet still acknowledged
  assign wrHit = cfgReq && cfgWrite && (slot != `RXSM_SLOT_NONE);
  // Every read refreshes the read register, unmapped ones with zero
  assign rdHit = cfgReq && !cfgWrite;

  ////////////////////////////////////////////////////////////////////////////////
  // Register storage, one write strobe per slot
  genvar g;
  generate
    for (g = 0; g < `RXSM_NUM_REGS; g++)
    begin : gReg
      localparam logic [7:0] RST_VAL = slotReset(3'(g));
      localparam logic [7:0] WR_MASK = slotMask(3'(g));
      assign wrEn[g] = wrHit && (slot == 3'(g));
      // One process per byte keeps each flop's driver unique
      always_ff @(posedge clk or posedge reset)
      begin
        if (reset)
        begin
          regFile_r[g] <= RST_VAL;
        end
        else if (wrEn[g])
        begin
          regFile_r[g] <= cfgWrData & WR_MASK;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Read path; unmapped offsets read zero
  // Case rather than an index, so the unmapped code never addresses the array
  always_comb
  begin
    rdData_nxt = '0;
    case (slot)
      `RXSM_SLOT_SYNTH_CTRL: rdData_nxt = regFile_r[`RXSM_SLOT_SYNTH_CTRL];
      `RXSM_SLOT_CARRIER_HI: rdData_nxt = regFile_r[`RXSM_SLOT_CARRIER_HI];
      `RXSM_SLOT_CARRIER_MID: rdData_nxt = regFile_r[`RXSM_SLOT_CARRIER_MID];
      `RXSM_SLOT_CARRIER_LO: rdData_nxt = regFile_r[`RXSM_SLOT_CARRIER_LO];
      `RXSM_SLOT_BW_RATE_EXP: rdData_nxt = regFile_r[`RXSM_SLOT_BW_RATE_EXP];
      `RXSM_SLOT_RATE_MANT: rdData_nxt = regFile_r[`RXSM_SLOT_RATE_MANT];
      `RXSM_SLOT_DEMOD_FMT: rdData_nxt = regFile_r[`RXSM_SLOT_DEMOD_FMT];
      default: rdData_nxt = '0;
    endcase
    // Masked again, so a stray top bit can never leak to the host
    rdData_nxt = rdData_nxt & slotMask(slot);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data register; holds until the next read
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cfgRdData <= '0;
    end
    else if (rdHit)
    begin
      cfgRdData <= rdData_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Acknowledge, one cycle after every request
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cfgAck <= 1'b0;
    end
    else
    begin
      cfgAck <= cfgReq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Field decoding toward synthesizer, decimator and demodulator
  assign rawRegs = '{
    synthControl: regFile_r[`RXSM_SLOT_SYNTH_CTRL],
    carrierHigh: regFile_r[`RXSM_SLOT_CARRIER_HI],
    carrierMiddle: regFile_r[`RXSM_SLOT_CARRIER_MID],
    carrierLow: regFile_r[`RXSM_SLOT_CARRIER_LO],
    bwRateExp: regFile_r[`RXSM_SLOT_BW_RATE_EXP],
    rateMantissa: regFile_r[`RXSM_SLOT_RATE_MANT],
    demodFormat: regFile_r[`RXSM_SLOT_DEMOD_FMT]
  };

  ////////////////////////////////////////////////////////////////////////////////
  // Settings decoder; its register drives cfgOut directly
  // Reserved modulation codes are stored as written; the flag warns the demodulator
  rxsm_field_decode #(
    .SYNTH_CTRL_RESET(SYNTH_CTRL_RESET)
  ) uDecode (
    .clk(clk),
    .reset(reset),
    .raw(rawRegs),
    .cfg(cfgOut)
  );

endmodule : rxsm_config_regs
`default_nettype wire

// [rxsm_asserts.sv]
// Purpose: Port checks of the synthesizer and modem config bank.
// Assumes: Bound to rxsm_config_regs.
// Notes: Settings land two edges after a write request.
`timescale 1ns/1ps
`default_nettype none
module rxsm_asserts
  import rxsm_pkg::*;
#(
  parameter int ADDR_W = 6
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic cfgReq,
  input wire logic cfgWrite,
  input wire logic [ADDR_W-1:0] cfgAddr,
  input wire logic [7:0] cfgWrData,
  input wire logic [7:0] cfgRdData,
  input wire logic cfgAck,
  input wire rxsm_cfg_t cfgOut
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  logic wrLo;
  logic wrFmt;
  assign wrLo = cfgReq && cfgWrite && cfgAddr == ADDR_W'(8'h0f);
  assign wrFmt = cfgReq && cfgWrite && cfgAddr == ADDR_W'(8'h12);
  //////////////////////////////
  AST_ACK_NEXT:
    assert property (cfgAck == $past(cfgReq)) else $error("ack not one cycle after request");
  AST_CARRIER_TOP:
    assert property (cfgOut.carrierWord[23:22] == 2'h0) else $error("carrier top bits set");
  AST_HI_READ:
    assert property (cfgReq && !cfgWrite && cfgAddr == ADDR_W'(8'h0d) |=> cfgRdData[7:6] == 2'h0)
      else $error("high carrier byte reads top bits");
  AST_LOW_BYTE:
    assert property (wrLo |-> ##2 cfgOut.carrierWord[7:0] == $past(cfgWrData, 2))
      else $error("low carrier byte not in word");
  AST_DECIM:
    assert property (cfgOut.decimationRatio ==
      ((9'h004 + 9'(cfgOut.bandwidthMantissa)) << 3 << cfgOut.bandwidthExponent))
      else $error("decimation ratio wrong");
  AST_RATE:
    assert property (cfgOut.symbolRateMantissa[8] && cfgOut.symbolRateScale ==
      (24'(cfgOut.symbolRateMantissa) << cfgOut.symbolRateExponent)) else $error("rate wrong");
  AST_BYPASS:
    assert property (wrFmt |-> ##2 cfgOut.dcBlockBypass == $past(cfgWrData[7], 2))
      else $error("bypass bit not applied");
  AST_MOD_SEL:
    assert property (wrFmt |-> ##2 cfgOut.modulationSelect == $past(cfgWrData[6:4], 2))
      else $error("modulation not applied");
  AST_MOD_VALID:
    assert property (cfgOut.modulationValid ==
      (cfgOut.modulationSelect inside {3'h0, 3'h1, 3'h3, 3'h4})) else $error("valid flag wrong");
  AST_RESET_LOAD:
    assert property ($fell(reset) |-> cfgOut.carrierWord == 24'h1ec4ec &&
      cfgOut.symbolRateScale == 24'h122000 && !cfgOut.dcBlockBypass) else $error("bad defaults");
endmodule : rxsm_asserts
bind rxsm_config_regs rxsm_asserts #(.ADDR_W(ADDR_W)) chk (.clk(clk), .reset(reset),
  .cfgReq(cfgReq), .cfgWrite(cfgWrite), .cfgAddr(cfgAddr), .cfgWrData(cfgWrData),
  .cfgRdData(cfgRdData), .cfgAck(cfgAck), .cfgOut(cfgOut));
`default_nettype wire

// [rxsm_host_model.sv]
// Purpose: Host side of the register port.
// Assumes: One-cycle request, ack one edge later.
// Notes: Released address and data lines show inverted values.
`timescale 1ns/1ps
`default_nettype none
module rxsm_host_model
(
  input wire logic clk,
  output logic cfgReq,
  output logic cfgWrite,
  output logic [5:0] cfgAddr,
  output logic [7:0] cfgWrData,
  input wire logic [7:0] cfgRdData,
  input wire logic cfgAck
);
  initial
  begin
    cfgReq = 1'b0;
    cfgWrite = 1'b0;
    cfgAddr = 6'h00;
    cfgWrData = 8'h00;
  end
  task automatic access(input logic w, input logic [5:0] a, input logic [7:0] d,
    output logic [7:0] rd, output int waits);
    int n;
    n = 0;
    @(negedge clk);
    cfgReq = 1'b1;
    cfgWrite = w;
    cfgAddr = a;
    cfgWrData = d;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end
    while (cfgAck !== 1'b1 && n < 4);
    // Gives up after four edges; the caller judges the wait count
    rd = cfgRdData;
    waits = n;
    @(negedge clk);
    cfgReq = 1'b0;
    // Stale bus must not look valid
    cfgAddr = ~a;
    cfgWrData = ~d;
  endtask : access
endmodule : rxsm_host_model
`default_nettype wire

// [rxsm_tb.sv]
// Purpose: Self-checking bench of the config bank.
// Assumes: Host model drives the port.
// Notes: Expectations from the field formulas.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import rxsm_pkg::*;
;
  logic clk;
  logic reset;
  logic cfgReq;
  logic cfgWrite;
  logic cfgAck;
  logic [5:0] cfgAddr;
  logic [7:0] cfgWrData;
  logic [7:0] cfgRdData;
  logic [7:0] rd;
  rxsm_cfg_t cfgOut;
  int numErrors = 0;
  int compares = 0;
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  rxsm_host_model hst (.clk(clk), .cfgReq(cfgReq), .cfgWrite(cfgWrite), .cfgAddr(cfgAddr),
    .cfgWrData(cfgWrData), .cfgRdData(cfgRdData), .cfgAck(cfgAck));
  rxsm_config_regs dut (.clk(clk), .reset(reset), .cfgReq(cfgReq), .cfgWrite(cfgWrite),
    .cfgAddr(cfgAddr), .cfgWrData(cfgWrData), .cfgRdData(cfgRdData), .cfgAck(cfgAck),
    .cfgOut(cfgOut));
  //////////////////////////////
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp)
    begin
      numErrors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    int waits;
    hst.access(1'b1, a, d, rd, waits);
    check("write ack", 24'(waits), 24'h000001);
  endtask : wr
  task automatic rdBack(input logic [5:0] a, input logic [7:0] exp);
    int waits;
    hst.access(1'b0, a, 8'h00, rd, waits);
    check("read ack", 24'(waits), 24'h000001);
    check("readback", 24'(rd), 24'(exp));
  endtask : rdBack
  task automatic settle();
    @(posedge clk);
    #1;
  endtask : settle
  task automatic test_defaults();
    logic [7:0] dflt [7] = '{8'h00, 8'h1e, 8'hc4, 8'hec, 8'h8c, 8'h22, 8'h02};
    check("rd reset", 24'(cfgRdData), 24'h000000);
    check("ack reset", 24'(cfgAck), 24'h000000);
    for (int i = 0; i < 7; i++) rdBack(6'(8'h0c + i), dflt[i]);
    check("synth", 24'(cfgOut.synthControl), 24'h000000);
    check("bypass", 24'(cfgOut.dcBlockBypass), 24'h000000);
    check("mod", 24'(cfgOut.modulationSelect), 24'h000000);
    check("valid", 24'(cfgOut.modulationValid), 24'h000001);
    check("word", cfgOut.carrierWord, 24'h1ec4ec);
    check("decim", 24'(cfgOut.decimationRatio), 24'd128);
    check("scale", cfgOut.symbolRateScale, 24'h122000);
  endtask : test_defaults
  task automatic test_carrier();
    wr(6'h0d, 8'hff);
    rdBack(6'h0d, 8'h3f);
    wr(6'h0e, 8'h5a);
    wr(6'h0f, 8'ha5);
    settle();
    check("word", cfgOut.carrierWord, 24'h3f5aa5);
  endtask : test_carrier
  task automatic test_rates();
    // Exponent fields walk every code together
    for (int i = 0; i < 16; i++)
    begin
      wr(6'h11, 8'(i * 17));
      wr(6'h10, 8'(i * 17));
      settle();
      check("decim", 24'(cfgOut.decimationRatio), 24'((8 * (4 + i % 4)) << (i / 4)));
      check("scale", cfgOut.symbolRateScale, 24'((256 + i * 17) << i));
      check("rate mant", 24'(cfgOut.symbolRateMantissa), 24'(256 + i * 17));
      check("rate exp", 24'(cfgOut.symbolRateExponent), 24'(i));
    end
  endtask : test_rates
  task automatic test_modes();
    // Low nibble kept at its default 2, bypass on the odd codes only, at the default bandwidth and rate exponents
    wr(6'h10, 8'h8c);
    for (int c = 0; c < 8; c++)
    begin
      wr(6'h12, {c[0], 3'(c), 4'h2});
      settle();
      check("bypass", 24'(cfgOut.dcBlockBypass), 24'(c[0]));
      check("mod", 24'(cfgOut.modulationSelect), 24'(c));
      check("valid", 24'(cfgOut.modulationValid), 24'(c inside {0, 1, 3, 4}));
      rdBack(6'h12, {c[0], 3'(c), 4'h2});
    end
  endtask : test_modes
  task automatic test_unmapped();
    wr(6'h20, 8'hff);
    rdBack(6'h20, 8'h00);
    check("word", cfgOut.carrierWord, 24'h3f5aa5);
    rdBack(6'h13, 8'h00);
    wr(6'h0c, 8'h3c);
    rdBack(6'h0c, 8'h3c);
    check("synth", 24'(cfgOut.synthControl), 24'h00003c);
  endtask : test_unmapped
  task automatic giveVerdict();
    $display("Errors %0d in %0d compares", numErrors, compares);
    if (numErrors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : giveVerdict
  //////////////////////////////
  initial
  begin
    #100000;
    numErrors++;
    giveVerdict();
  end
  initial
  begin
    reset = 1'b1;
    repeat (4) @(negedge clk);
    reset = 1'b0;
    test_defaults();
    test_carrier();
    test_rates();
    test_modes();
    test_unmapped();
    // Mid-run reset must restore every default
    @(negedge clk);
    reset = 1'b1;
    repeat (4) @(negedge clk);
    reset = 1'b0;
    test_defaults();
    giveVerdict();
  end
endmodule : tb_top
`default_nettype wire
